// ### nvsram_spi_ctl.sv
// SPI slave command logic: memory writes, special commands, pause
`timescale 1ns/100ps
`include "nvsram_spi_defines.svh"
module nvsram_spi_ctl
	import nvsram_spi_pkg::*;
#(
	parameter int FIFO_DEPTH = `FIFO_DEPTH,
	parameter int BUSY_CYC = `SPECIAL_CMD_BUSY_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic cs_b,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_b,
	output logic so_o,
	output logic so_oe,
	input wire logic block_protect_low_bit,
	input wire logic block_protect_high_bit,
	input wire logic nv_done,
	output logic store_req,
	output logic recall_req,
	output logic busy,
	output logic write_enable_latch,
	output logic power_loss_autosave,
	output logic write_overrun,
	output logic mem_wr_valid,
	output logic [`ADDR_W-1:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	input wire logic mem_wr_ready
);
	localparam int WORD_W = `ADDR_W + 8;

	ctl_state_s q_ff;
	ctl_state_s nxt_q;
	logic sck_rise;
	logic cs_rise;
	logic paused;
	logic selected;
	logic [7:0] byte_in;
	logic [1:0] bp;

	wr_fifo_if #(.WIDTH(WORD_W)) fch ();

	wr_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.ch(fch)
	);

	function automatic logic addr_protected(input logic [`ADDR_W-1:0] a, input logic [1:0] b);
		logic p;
		p = 1'b0;
		unique case (b)
			`BP_NONE: p = 1'b0;
			`BP_QUARTER: p = (a[`ADDR_W-1:`ADDR_W-2] == 2'b11);
			`BP_HALF: p = a[`ADDR_W-1];
			`BP_ALL: p = 1'b1;
		endcase
		return p;
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_q = q_ff;
		bp = {block_protect_high_bit, block_protect_low_bit};
		fch.push_valid = 1'b0;
		fch.push_data = {q_ff.addr, 8'h00};
		fch.pop_ready = !q_ff.out_valid || mem_wr_ready;

		// Pin synchronisers; second stages are read below, plus the cs_d and sck_d delay stages for edge detection
		nxt_q.cs_s1 = cs_b;
		nxt_q.cs_s2 = q_ff.cs_s1;
		nxt_q.cs_d = q_ff.cs_s2;
		nxt_q.sck_s1 = sck;
		nxt_q.sck_s2 = q_ff.sck_s1;
		nxt_q.sck_d = q_ff.sck_s2;
		nxt_q.si_s1 = si;
		nxt_q.si_s2 = q_ff.si_s1;
		nxt_q.hold_s1 = hold_b;
		nxt_q.hold_s2 = q_ff.hold_s1;

		selected = !q_ff.cs_s2;
		paused = selected && !q_ff.hold_s2;
		sck_rise = q_ff.sck_s2 && !q_ff.sck_d && selected && !paused;
		cs_rise = q_ff.cs_s2 && !q_ff.cs_d;
		byte_in = {q_ff.shreg[6:0], q_ff.si_s2};

		nxt_q.store_req = 1'b0;
		nxt_q.recall_req = 1'b0;

		// Busy from nonvolatile cycles and autosave setting time
		if (nv_done) begin
			nxt_q.busy_nv = 1'b0;
		end
		if (q_ff.busy_cnt != '0) begin
			nxt_q.busy_cnt = q_ff.busy_cnt - 1'b1;
		end

		if (selected && q_ff.st == ST_IDLE) begin
			nxt_q.st = ST_OPCODE;
			nxt_q.bit_cnt = 3'h0;
			nxt_q.cmd = `OP_NONE;
		end

		// Shifter; paused cycles leave all of this untouched
		if (sck_rise && q_ff.st != ST_IDLE) begin
			nxt_q.shreg = byte_in;
			nxt_q.bit_cnt = q_ff.bit_cnt + 1'b1;
			if (q_ff.bit_cnt == 3'h7) begin
				unique case (q_ff.st)
					ST_OPCODE: begin
						nxt_q.st = ST_IGNORE;
						if (byte_in == `OP_SET_WRITE_ENABLE) begin
							nxt_q.cmd = byte_in;
						end else if (q_ff.wel && !q_ff.busy) begin
							unique case (byte_in)
								`OP_WRITE: begin
									nxt_q.cmd = byte_in;
									nxt_q.st = ST_ADDR;
									nxt_q.byte_cnt = 2'h0;
								end
								`OP_STORE, `OP_RECALL: nxt_q.cmd = byte_in;
								`OP_AUTOSAVE_ON, `OP_AUTOSAVE_OFF: nxt_q.cmd = byte_in;
								default: nxt_q.cmd = `OP_NONE;
							endcase
						end
					end
					ST_ADDR: begin
						nxt_q.byte_cnt = q_ff.byte_cnt + 1'b1;
						unique case (q_ff.byte_cnt)
							2'h0: nxt_q.addr[`ADDR_W-1] = byte_in[`TOP_ADDR_BIT_POS];
							2'h1: nxt_q.addr[15:8] = byte_in;
							default: begin
								nxt_q.addr[7:0] = byte_in;
								nxt_q.st = ST_DATA;
							end
						endcase
					end
					ST_DATA: begin
						if (!addr_protected(q_ff.addr, bp)) begin
							fch.push_valid = 1'b1;
							fch.push_data = {q_ff.addr, byte_in};
							if (!fch.push_ready) begin
								nxt_q.overrun = 1'b1;
							end
						end
						// Natural 17-bit overflow takes the top address to zero
						nxt_q.addr = q_ff.addr + 1'b1;
					end
					default: nxt_q.st = ST_IGNORE;
				endcase
			end
		end

		// Deselect ends the command; partial opcodes leave cmd empty
		if (cs_rise) begin
			nxt_q.st = ST_IDLE;
			nxt_q.bit_cnt = 3'h0;
			nxt_q.cmd = `OP_NONE;
			unique case (q_ff.cmd)
				`OP_SET_WRITE_ENABLE: nxt_q.wel = 1'b1;
				`OP_WRITE: nxt_q.wel = 1'b0;
				`OP_STORE: begin
					nxt_q.wel = 1'b0;
					nxt_q.store_req = 1'b1;
					nxt_q.busy_nv = 1'b1;
				end
				`OP_RECALL: begin
					nxt_q.wel = 1'b0;
					nxt_q.recall_req = 1'b1;
					nxt_q.busy_nv = 1'b1;
				end
				`OP_AUTOSAVE_ON: begin
					nxt_q.wel = 1'b0;
					nxt_q.autosave = 1'b1;
					nxt_q.busy_cnt = `BUSY_CNT_W'(BUSY_CYC);
				end
				`OP_AUTOSAVE_OFF: begin
					nxt_q.wel = 1'b0;
					nxt_q.autosave = 1'b0;
					nxt_q.busy_cnt = `BUSY_CNT_W'(BUSY_CYC);
				end
				default: nxt_q.wel = q_ff.wel;
			endcase
		end

		nxt_q.busy = nxt_q.busy_nv || (nxt_q.busy_cnt != '0);

		// Output stage toward the array write port
		if (fch.pop_ready) begin
			nxt_q.out_valid = fch.pop_valid;
			if (fch.pop_valid) begin
				nxt_q.out_addr = fch.pop_data[WORD_W-1:8];
				nxt_q.out_data = fch.pop_data[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q_ff <= '0;
			q_ff.cs_s1 <= 1'b1;
			q_ff.cs_s2 <= 1'b1;
			q_ff.cs_d <= 1'b1;
			q_ff.hold_s1 <= 1'b1;
			q_ff.hold_s2 <= 1'b1;
			q_ff.st <= ST_IDLE;
			q_ff.cmd <= `OP_NONE;
			q_ff.wel <= `WEL_RESET;
			q_ff.autosave <= `AUTOSAVE_RESET;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Reads are not served here, so SO never leaves high impedance
	assign so_o = 1'b0;
	assign so_oe = 1'b0;
	assign store_req = q_ff.store_req;
	assign recall_req = q_ff.recall_req;
	assign busy = q_ff.busy;
	assign write_enable_latch = q_ff.wel;
	assign power_loss_autosave = q_ff.autosave;
	assign write_overrun = q_ff.overrun;
	assign mem_wr_valid = q_ff.out_valid;
	assign mem_wr_addr = q_ff.out_addr;
	assign mem_wr_data = q_ff.out_data;
endmodule // nvsram_spi_ctl

// ### nvsram_spi_ctl_monitor.sv
// Port assertions for the nvSRAM command block
`timescale 1ns/100ps
`include "nvsram_spi_defines.svh"
module nvsram_spi_ctl_monitor #(parameter int BUSY_CYC = 20) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic so_oe,
	input wire logic store_req,
	input wire logic recall_req,
	input wire logic busy,
	input wire logic write_enable_latch,
	input wire logic power_loss_autosave,
	input wire logic mem_wr_valid,
	input wire logic [`ADDR_W-1:0] mem_wr_addr,
	input wire logic [7:0] mem_wr_data,
	input wire logic mem_wr_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_so_floats: assert property (so_oe == 1'b0) else $error("SO driven");
	a_store_pulse: assert property (store_req |=> !store_req) else $error("save pulse long");
	a_nv_busy: assert property (store_req || recall_req |-> ##[0:1] busy) else $error("no busy");
	a_special_wel: assert property (store_req || recall_req |-> ##[0:1] !write_enable_latch)
		else $error("latch kept");
	a_wr_stands: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr)
		&& $stable(mem_wr_data)) else $error("write word changed");
	a_wel_at_cs: assert property ($rose(write_enable_latch) |-> cs_b) else $error("latch set in frame");
	a_auto_busy: assert property ($changed(power_loss_autosave) |-> ##[0:1] busy[*3] ##[1:BUSY_CYC] !busy)
		else $error("autosave busy time");
	a_reset_vals: assert property ($rose(rst_b) |-> !write_enable_latch && power_loss_autosave && !busy)
		else $error("reset values");
	cover property (store_req);
	cover property (recall_req);
	cover property (mem_wr_valid && mem_wr_ready);
endmodule // nvsram_spi_ctl_monitor
bind nvsram_spi_ctl nvsram_spi_ctl_monitor #(.BUSY_CYC(BUSY_CYC)) nvsram_spi_ctl_monitor_i (.clk(clk), .rst_b(rst_b),
	.cs_b(cs_b), .so_oe(so_oe), .store_req(store_req), .recall_req(recall_req), .busy(busy),
	.write_enable_latch(write_enable_latch), .power_loss_autosave(power_loss_autosave), .mem_wr_valid(mem_wr_valid),
	.mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));

// ### nvsram_spi_defines.svh
// Constants for the serial nvSRAM command block
`ifndef NVSRAM_SPI_DEFINES_SVH
`define NVSRAM_SPI_DEFINES_SVH

`define ADDR_W 17
`define ADDR_TOP 17'h1_FFFF
`define ADDR_WRAP 17'h0_0000
`define TOP_ADDR_BIT_POS 0
`define FIFO_DEPTH 16

`define OP_NONE 8'h00
`define OP_SET_WRITE_ENABLE 8'h06
`define OP_WRITE 8'h02
`define OP_STORE 8'h3C
`define OP_RECALL 8'h60
`define OP_AUTOSAVE_ON 8'h59
`define OP_AUTOSAVE_OFF 8'h19

`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3

`define WEL_RESET 1'b0
`define AUTOSAVE_RESET 1'b1

`define CLK_PERIOD_NS 25
`define SPECIAL_CMD_BUSY_TIME_NS 500
`define SPECIAL_CMD_BUSY_CYC ((`SPECIAL_CMD_BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_CNT_W 8

`endif

// ### nvsram_spi_pkg.sv
// Types for the serial nvSRAM command block
`include "nvsram_spi_defines.svh"
package nvsram_spi_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b011,
		ST_IGNORE = 3'b100
	} ser_state_e;

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_d;
		logic sck_s1;
		logic sck_s2;
		logic sck_d;
		logic si_s1;
		logic si_s2;
		logic hold_s1;
		logic hold_s2;
		ser_state_e st;
		logic [2:0] bit_cnt;
		logic [1:0] byte_cnt;
		logic [7:0] shreg;
		logic [7:0] cmd;
		logic [`ADDR_W-1:0] addr;
		logic wel;
		logic autosave;
		logic busy_nv;
		logic [`BUSY_CNT_W-1:0] busy_cnt;
		logic busy;
		logic store_req;
		logic recall_req;
		logic overrun;
		logic out_valid;
		logic [`ADDR_W-1:0] out_addr;
		logic [7:0] out_data;
	} ctl_state_s;
endpackage

// ### spi_master_model.sv
// SPI bus master, mode 0, with optional pause in mid-frame
`timescale 1ns/100ps
module spi_master_model (
	output logic cs_b,
	output logic sck,
	output logic si,
	output logic hold_b
);
	initial begin
		cs_b = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_b = 1'b1;
	end
	task automatic frame(input logic [7:0] q[$], input int nbits, input bit pz);
		#200 cs_b = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			if (pz && i == 20) begin
				#50 hold_b = 1'b0;
				repeat (3) begin
					si = ~si;
					#100 sck = 1'b1;
					#100 sck = 1'b0;
				end
				#50 hold_b = 1'b1;
			end
			si = q[i / 8][7 - i % 8];
			#100 sck = 1'b1;
			#100 sck = 1'b0;
		end
		#100 cs_b = 1'b1;
		si = ~si;
	endtask
endmodule // spi_master_model

// ### spi_nvsram_write_special_cmds_bench.sv
// Self-checking bench for the nvSRAM command block
`timescale 1ns/100ps
module spi_nvsram_write_special_cmds_bench;
	logic clk = 0, rst_b = 0, bp_lo = 0, bp_hi = 0, nv_done = 0, rdy = 0, stall = 0, loose = 0, ce = 1;
	logic cs_b, sck, si, hold_b, so_o, so_oe, st, rc, busy, wel, pla, ovr, wv;
	logic [16:0] wa;
	logic [7:0] wd;
	logic [24:0] exp_q[$];
	logic [7:0] ops[5] = '{8'h3C, 8'h60, 8'h19, 8'h59, 8'h3C};
	logic [4:0] ea = 5'b11011;
	int err_count = 0, n_tests = 0, n_st = 0, n_rc = 0;
	always #12.5 clk = ~clk;
	nvsram_spi_ctl #(.BUSY_CYC(8)) nvsram_spi_ctl_i (.clk(clk), .rst_b(rst_b), .ce(ce), .cs_b(cs_b), .sck(sck),
		.si(si), .hold_b(hold_b), .so_o(so_o), .so_oe(so_oe), .block_protect_low_bit(bp_lo),
		.block_protect_high_bit(bp_hi), .nv_done(nv_done), .store_req(st), .recall_req(rc), .busy(busy),
		.write_enable_latch(wel), .power_loss_autosave(pla), .write_overrun(ovr), .mem_wr_valid(wv),
		.mem_wr_addr(wa), .mem_wr_data(wd), .mem_wr_ready(rdy));
	spi_master_model spi_master_model_i (.cs_b(cs_b), .sck(sck), .si(si), .hold_b(hold_b));
	task automatic chk(input logic got, input logic exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_wr(input logic [24:0] got, input logic [24:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: array write %h", $time, got);
		end
	endtask
	task automatic end_of_test;
		$display("%0d checks, %0d errors", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	function automatic bit prot(input logic [16:0] x);
		return {bp_hi, bp_lo} == 2'h3 || ({bp_hi, bp_lo} == 2'h2 && x[16]) || ({bp_hi, bp_lo} == 2'h1 && &x[16:15]);
	endfunction
	task automatic settle;
		repeat (8) @(negedge clk);
	endtask
	task automatic op(input logic [7:0] c, input int n);
		spi_master_model_i.frame('{c}, n, 0);
		settle();
	endtask
	task automatic wr(input logic [16:0] a, input int n, input bit pz, input bit en);
		logic [7:0] q[$];
		logic [16:0] x;
		logic [7:0] d;
		q = '{8'h02, {7'h55, a[16]}, a[15:8], a[7:0]};
		for (int i = 0; i < n; i++) begin
			x = a + 17'(i);
			d = 8'($urandom);
			q.push_back(d);
			if (en && !prot(x)) exp_q.push_back({x, d});
		end
		spi_master_model_i.frame(q, 8 * q.size(), pz);
		settle();
	endtask
	always @(negedge clk) rdy <= !stall && $urandom_range(3) != 0;
	always @(posedge clk) begin
		if (st === 1'b1) n_st++;
		if (rc === 1'b1) n_rc++;
		if (wv === 1'b1 && rdy && !loose) chk_wr({wa, wd}, exp_q.size() ? exp_q.pop_front() : ~{wa, wd});
	end
	initial begin
		void'($urandom(32'hf806_031a));
		repeat (8) @(negedge clk);
		rst_b = 1;
		settle();
		chk(wel, 0, "latch at reset");
		chk(pla, 1, "autosave at reset");
		wr(17'h0_0010, 1, 0, 0);
		op(8'h06, 8);
		chk(wel, 1, "latch set");
		wr(17'h1_FFFE, 3, 1, 1);
		chk(wel, 0, "latch after write");
		chk(so_oe, 1'b0, "SO enable");
		chk(so_o, 1'b0, "SO level");
		bp_lo = 1;
		op(8'h06, 8);
		wr(17'h1_FFFF, 2, 0, 1);
		bp_lo = 0;
		bp_hi = 1;
		op(8'h06, 8);
		wr(17'h0_FFFF, 2, 0, 1);
		bp_lo = 1;
		op(8'h06, 8);
		wr(17'h0_0040, 1, 0, 1);
		chk(wel, 1'b0, "latch after protected write");
		bp_hi = 0;
		bp_lo = 0;
		for (int i = 0; i < 5; i++) begin
			op(8'h06, 8);
			op(ops[i], 8);
			chk(busy, 1, "busy");
			chk(wel, 0, "latch after command");
			chk(pla, ea[i], "autosave");
			if (i == 0) begin
				op(8'h06, 8);
				wr(17'h0_0200, 1, 0, 0);
			end
			settle();
			nv_done = 1;
			@(negedge clk) nv_done = 0;
			settle();
			chk(busy, 0, "busy end");
		end
		chk(n_st == 2, 1, "save count");
		chk(n_rc == 1, 1, "restore count");
		op(8'h06, 8);
		op(8'h3C, 5);
		chk(busy, 0, "partial opcode");
		chk(wel, 1'b1, "latch kept on partial opcode");
		chk(exp_q.size() == 0, 1, "writes missing");
		loose = 1;
		stall = 1;
		wr(17'h0_0100, 20, 0, 0);
		chk(ovr, 1, "overrun");
		ce = 0;
		stall = 0;
		settle();
		chk(wv, 1'b1, "frozen by enable");
		ce = 1;
		repeat (10) settle();
		chk(wv, 0, "drained");
		end_of_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule // spi_nvsram_write_special_cmds_bench

// ### wr_fifo.sv
// Synchronous FIFO holding pending memory writes
`timescale 1ns/100ps
module wr_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	wr_fifo_if.fifo ch
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW:0] wp;
		logic [PW:0] rp;
	} fifo_s;

	fifo_s q_ff;
	fifo_s nxt_q;
	logic full;
	logic empty;

	////////////////////////////////////////////////////////////////
	always_comb begin
		full = (q_ff.wp[PW] != q_ff.rp[PW]) && (q_ff.wp[PW-1:0] == q_ff.rp[PW-1:0]);
		empty = (q_ff.wp == q_ff.rp);
		nxt_q = q_ff;
		if (ch.push_valid && !full) begin
			nxt_q.mem[q_ff.wp[PW-1:0]] = ch.push_data;
			nxt_q.wp = q_ff.wp + 1'b1;
		end
		if (ch.pop_ready && !empty) begin
			nxt_q.rp = q_ff.rp + 1'b1;
		end
	end

	assign ch.push_ready = !full;
	assign ch.pop_valid = !empty;
	assign ch.pop_data = q_ff.mem[q_ff.rp[PW-1:0]];

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q_ff <= '0;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end
endmodule // wr_fifo

// ### wr_fifo_if.sv
// Push and pop channel between command logic and write FIFO
`timescale 1ns/100ps
interface wr_fifo_if #(parameter int WIDTH = 25);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	modport fifo (input push_valid, input push_data, output push_ready,
		output pop_valid, output pop_data, input pop_ready);
	modport user (output push_valid, output push_data, input push_ready,
		input pop_valid, input pop_data, output pop_ready);
endinterface // wr_fifo_if
